// ===== design/descriptor_attribute_regs.sv
// Descriptor attribute register bank with the EEPROM byte buffer.
// Assumes an AXI4-Lite master, an EEPROM controller and an image loader
// on the same clock; reset protection is decided outside this block.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module descriptor_attribute_regs
  import desc_attr_pkg::*;
(
  input  wire logic        aclk,             // 50 MHz clock
  input  wire logic        aresetn,          // Synchronous, active low
  // AXI4-Lite slave
  input  wire logic [11:0] s_axi_awaddr,     // Write address
  input  wire logic        s_axi_awvalid,    // Write address valid
  output logic             s_axi_awready,    // Write address ready
  input  wire logic [31:0] s_axi_wdata,      // Write data
  input  wire logic [3:0]  s_axi_wstrb,      // Byte enables
  input  wire logic        s_axi_wvalid,     // Write data valid
  output logic             s_axi_wready,     // Write data ready
  output logic [1:0]       s_axi_bresp,      // Write response
  output logic             s_axi_bvalid,     // Write response valid
  input  wire logic        s_axi_bready,     // Write response ready
  input  wire logic [11:0] s_axi_araddr,     // Read address
  input  wire logic        s_axi_arvalid,    // Read address valid
  output logic             s_axi_arready,    // Read address ready
  output logic [31:0]      s_axi_rdata,      // Read data
  output logic [1:0]       s_axi_rresp,      // Read response
  output logic             s_axi_rvalid,     // Read data valid
  input  wire logic        s_axi_rready,     // Read data ready
  // Image source and reset events
  input  wire logic        usb_reset,        // USB reset pulse
  input  wire logic        lite_reset,       // Lite reset pulse
  input  wire logic        image_load,       // Image load done pulse
  input  wire logic        eeprom_present,   // EEPROM image found
  input  wire logic        otp_configured,   // OTP image configured
  input  wire logic        emulation_select_bit, // Use RAM plus attributes
  input  wire logic [7:0]  img_bos_len,      // Image BOS length
  input  wire logic [7:0]  img_ss_poll,      // Image SS poll interval
  input  wire logic [7:0]  img_ss_dev_len,   // Image SS device length
  input  wire logic [7:0]  img_ss_cfg_len,   // Image SS config length
  input  wire logic [7:0]  img_hs_poll,      // Image HS poll interval
  input  wire logic [7:0]  img_hs_dev_len,   // Image HS device length
  input  wire logic [7:0]  img_hs_cfg_len,   // Image HS config length
  // EEPROM controller data path
  input  wire logic        epc_read_done,    // Read command finished
  input  wire logic [7:0]  epc_read_byte,    // Byte fetched
  output logic [7:0]       eeprom_byte_value, // Byte to write
  // Attributes seen by descriptor processing
  output logic             attr_active,      // Attributes in force
  output logic [7:0]       bos_len_eff,      // Effective BOS length
  output logic [7:0]       ss_poll_eff,      // Effective SS poll
  output logic [7:0]       ss_dev_len_eff,   // Effective SS device len
  output logic [7:0]       ss_cfg_len_eff,   // Effective SS config len
  output logic [7:0]       hs_poll_eff,      // Effective HS poll
  output logic [7:0]       hs_dev_len_eff,   // Effective HS device len
  output logic [7:0]       hs_cfg_len_eff    // Effective HS config len
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] byte_buf_r;                    // Byte buffer field
  logic [7:0] bos_len_r;                     // BOS block length
  logic [7:0] ss_poll_r;                     // SS poll interval
  logic [7:0] ss_dev_r;                      // SS device length raw
  logic [7:0] ss_cfg_r;                      // SS config length raw
  logic [7:0] hs_poll_r;                     // HS poll interval
  logic [7:0] hs_dev_r;                      // HS device length
  logic [7:0] hs_cfg_r;                      // HS config length
  // Image shadow: what a USB or lite reset brings back
  logic [7:0] sh_bos_r;
  logic [7:0] sh_ss_poll_r;
  logic [7:0] sh_ss_dev_r;
  logic [7:0] sh_ss_cfg_r;
  logic [7:0] sh_hs_poll_r;
  logic [7:0] sh_hs_dev_r;
  logic [7:0] sh_hs_cfg_r;
  // Bus state
  logic        aw_hold_r;                    // Address captured
  logic        w_hold_r;                     // Data captured
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        do_write;                     // Both halves present
  logic        wr_hit;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        restore;                      // USB or lite reset
  logic        img_src;                      // Any image source exists
  logic [7:0]  ss_dev_clamp;
  logic [7:0]  ss_cfg_clamp;

  assign img_src  = eeprom_present | otp_configured;
  assign restore  = usb_reset | lite_reset;
  assign do_write = aw_hold_r & w_hold_r & ~s_axi_bvalid;

  // Byte-enabled merge of an 8-bit field held in one lane
  function automatic logic [7:0] merge8(input logic [7:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s,
                                        input int lane);
    merge8 = s[lane] ? d[lane*8 +: 8] : old;
  endfunction

  // Image value or fixed default when no source exists
  function automatic logic [7:0] pick(input logic src,
                                      input logic [7:0] img,
                                      input logic [7:0] dflt);
    pick = src ? img : dflt;
  endfunction

  // ------------------------------------------------------------
  // AXI write channels: address and data accepted in either order
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      // Capture each half once; hold until the response is issued
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
      end
    end
  end

  // Ready flops: low while a half is held, so each moves once
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_hold_r & ~(s_axi_awvalid & s_axi_awready)
                       & ~s_axi_bvalid;
      s_axi_wready  <= ~w_hold_r & ~(s_axi_wvalid & s_axi_wready)
                       & ~s_axi_bvalid;
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Address decode of the four mapped words
  always_comb
  begin
    wr_hit = (aw_addr_r == OFF_BYTE_BUF) || (aw_addr_r == OFF_BOS) ||
             (aw_addr_r == OFF_SS) || (aw_addr_r == OFF_HS);
  end

  // ------------------------------------------------------------
  // Byte buffer: software and EEPROM controller share it
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      byte_buf_r <= 8'h00;
    else if (epc_read_done)
      byte_buf_r <= epc_read_byte;
    else if (do_write && aw_addr_r == OFF_BYTE_BUF)
      byte_buf_r <= merge8(byte_buf_r, w_data_r, w_strb_r, 0);
  end

  // Write commands take the byte from here
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      eeprom_byte_value <= 8'h00;
    else
      eeprom_byte_value <= byte_buf_r;
  end

  // ------------------------------------------------------------
  // Image shadow, refreshed on each successful image load
  // ------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sh_bos_r     <= LEN_DFLT;
      sh_ss_poll_r <= SS_POLL_DFLT;
      sh_ss_dev_r  <= LEN_DFLT;
      sh_ss_cfg_r  <= LEN_DFLT;
      sh_hs_poll_r <= HS_POLL_DFLT;
      sh_hs_dev_r  <= LEN_DFLT;
      sh_hs_cfg_r  <= LEN_DFLT;
    end
    else if (image_load)
    begin
      // EEPROM ranks over OTP; the loader presents the winner
      sh_bos_r     <= pick(img_src, img_bos_len, LEN_DFLT);
      sh_ss_poll_r <= pick(img_src, img_ss_poll, SS_POLL_DFLT);
      sh_ss_dev_r  <= pick(img_src, img_ss_dev_len, LEN_DFLT);
      sh_ss_cfg_r  <= pick(img_src, img_ss_cfg_len, LEN_DFLT);
      sh_hs_poll_r <= pick(img_src, img_hs_poll, HS_POLL_DFLT);
      sh_hs_dev_r  <= pick(img_src, img_hs_dev_len, LEN_DFLT);
      sh_hs_cfg_r  <= pick(img_src, img_hs_cfg_len, LEN_DFLT);
    end
  end

  // ------------------------------------------------------------
  // Attribute fields; USB or lite reset restores the shadow
  // ------------------------------------------------------------
  // Reset protection is applied upstream by gating usb_reset and
  // lite_reset; this bank restores on whatever reaches it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bos_len_r <= LEN_DFLT;
      ss_poll_r <= SS_POLL_DFLT;
      ss_dev_r  <= LEN_DFLT;
      ss_cfg_r  <= LEN_DFLT;
      hs_poll_r <= HS_POLL_DFLT;
      hs_dev_r  <= LEN_DFLT;
      hs_cfg_r  <= LEN_DFLT;
    end
    else if (image_load)
    begin
      // Fresh image lands in the live fields too
      bos_len_r <= pick(img_src, img_bos_len, LEN_DFLT);
      ss_poll_r <= pick(img_src, img_ss_poll, SS_POLL_DFLT);
      ss_dev_r  <= pick(img_src, img_ss_dev_len, LEN_DFLT);
      ss_cfg_r  <= pick(img_src, img_ss_cfg_len, LEN_DFLT);
      hs_poll_r <= pick(img_src, img_hs_poll, HS_POLL_DFLT);
      hs_dev_r  <= pick(img_src, img_hs_dev_len, LEN_DFLT);
      hs_cfg_r  <= pick(img_src, img_hs_cfg_len, LEN_DFLT);
    end
    else if (restore)
    begin
      bos_len_r <= sh_bos_r;
      ss_poll_r <= sh_ss_poll_r;
      ss_dev_r  <= sh_ss_dev_r;
      ss_cfg_r  <= sh_ss_cfg_r;
      hs_poll_r <= sh_hs_poll_r;
      hs_dev_r  <= sh_hs_dev_r;
      hs_cfg_r  <= sh_hs_cfg_r;
    end
    else if (do_write)
    begin
      // Only the defined byte lanes store; upper lane is reserved
      case (aw_addr_r)
        OFF_BOS:
          bos_len_r <= merge8(bos_len_r, w_data_r, w_strb_r, 0);
        OFF_SS:
        begin
          ss_poll_r <= merge8(ss_poll_r, w_data_r, w_strb_r, 2);
          ss_dev_r  <= merge8(ss_dev_r, w_data_r, w_strb_r, 1);
          ss_cfg_r  <= merge8(ss_cfg_r, w_data_r, w_strb_r, 0);
        end
        OFF_HS:
        begin
          hs_poll_r <= merge8(hs_poll_r, w_data_r, w_strb_r, 2);
          hs_dev_r  <= merge8(hs_dev_r, w_data_r, w_strb_r, 1);
          hs_cfg_r  <= merge8(hs_cfg_r, w_data_r, w_strb_r, 0);
        end
        default:
          bos_len_r <= bos_len_r;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      OFF_BYTE_BUF: rd_word = {24'h000000, byte_buf_r};
      OFF_BOS:      rd_word = {24'h000000, bos_len_r};
      OFF_SS:       rd_word = {8'h00, ss_poll_r, ss_dev_r, ss_cfg_r};
      OFF_HS:       rd_word = {8'h00, hs_poll_r, hs_dev_r, hs_cfg_r};
      default:      rd_hit  = 1'b0;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Effective attributes for descriptor processing
  // ------------------------------------------------------------
  len_clamp u_ss_dev (.raw_len(ss_dev_r), .eff_len(ss_dev_clamp));
  len_clamp u_ss_cfg (.raw_len(ss_cfg_r), .eff_len(ss_cfg_clamp));

  // Attributes count only in emulation with no image source
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      attr_active    <= 1'b0;
      bos_len_eff    <= LEN_DFLT;
      ss_poll_eff    <= SS_POLL_DFLT;
      ss_dev_len_eff <= LEN_DFLT;
      ss_cfg_len_eff <= LEN_DFLT;
      hs_poll_eff    <= HS_POLL_DFLT;
      hs_dev_len_eff <= LEN_DFLT;
      hs_cfg_len_eff <= LEN_DFLT;
    end
    else
    begin
      attr_active    <= ~img_src & emulation_select_bit;
      bos_len_eff    <= bos_len_r;
      ss_poll_eff    <= ss_poll_r;
      ss_dev_len_eff <= ss_dev_clamp;
      ss_cfg_len_eff <= ss_cfg_clamp;
      hs_poll_eff    <= hs_poll_r;
      hs_dev_len_eff <= hs_dev_r;
      hs_cfg_len_eff <= hs_cfg_r;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  ss_clamp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ss_dev_r != 8'h00 |=> ss_dev_len_eff == DESC_LEN_STD || $past(restore))
    else $error("SS device length not clamped");
  restore_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
    restore && !image_load |=> bos_len_r == $past(sh_bos_r))
    else $error("BOS length not restored");
  buf_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    epc_read_done |=> byte_buf_r == $past(epc_read_byte))
    else $error("Read byte not captured");
  active_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    img_src |=> !attr_active)
    else $error("Attributes active with image source");
  ss_poll_dflt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    image_load && !img_src |=> ss_poll_r == SS_POLL_DFLT)
    else $error("SS poll default wrong");
  hs_poll_dflt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    image_load && !img_src |=> hs_poll_r == HS_POLL_DFLT)
    else $error("HS poll default wrong");
  rsvd_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
    else $error("Reserved bits read nonzero");
  wr_byte_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> eeprom_byte_value == $past(byte_buf_r))
    else $error("Write byte does not follow buffer");
endmodule
`default_nettype wire

// ===== common/desc_attr_pkg.sv
// Package for the descriptor attribute register group.
// Assumes a 32-bit AXI4-Lite register space, word aligned.
package desc_attr_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_BYTE_BUF = 12'h044;
  localparam logic [11:0] OFF_BOS      = 12'h050;
  localparam logic [11:0] OFF_SS       = 12'h054;
  localparam logic [11:0] OFF_HS       = 12'h058;
  // Field positions within the attribute registers
  localparam int POLL_LSB = 16;
  localparam int DEV_LSB  = 8;
  localparam int CFG_LSB  = 0;
  // Fixed defaults when no image source exists
  localparam logic [7:0] SS_POLL_DFLT = 8'h06;
  localparam logic [7:0] HS_POLL_DFLT = 8'h04;
  localparam logic [7:0] LEN_DFLT     = 8'h00;
  // The only nonzero legal descriptor length
  localparam logic [7:0] DESC_LEN_STD = 8'h12;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== design/len_clamp.sv
// Small helper: clamps a SuperSpeed length field to zero or the standard.
// Assumes pure combinational use by the attribute register bank.
`timescale 1ns/1ps
`default_nettype none
module len_clamp
  import desc_attr_pkg::*;
(
  input  wire logic [7:0] raw_len,   // Stored software value
  output logic      [7:0] eff_len    // Value used by descriptor logic
);
  // Any nonzero value is taken as the standard length
  always_comb
  begin
    eff_len = (raw_len == LEN_DFLT) ? LEN_DFLT : DESC_LEN_STD;
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the descriptor attribute register bank.
// Assumes the design package is compiled first; one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb
  import desc_attr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------
  logic        aclk, aresetn;                       // Clock, reset
  logic [11:0] s_axi_awaddr, s_axi_araddr;          // Addresses
  logic [31:0] s_axi_wdata, s_axi_rdata;            // Data
  logic [3:0]  s_axi_wstrb;                         // Byte enables
  logic [1:0]  s_axi_bresp, s_axi_rresp;            // Responses
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        usb_reset, lite_reset, image_load, eeprom_present;
  logic        otp_configured, emulation_select_bit, epc_read_done;
  logic [7:0]  img_bos_len, img_ss_poll, img_ss_dev_len, img_ss_cfg_len;
  logic [7:0]  img_hs_poll, img_hs_dev_len, img_hs_cfg_len, epc_read_byte;
  logic [7:0]  eeprom_byte_value, bos_len_eff, ss_poll_eff, ss_dev_len_eff;
  logic [7:0]  ss_cfg_len_eff, hs_poll_eff, hs_dev_len_eff, hs_cfg_len_eff;
  logic        attr_active;                         // Attributes in force
  typedef struct { logic [31:0] d; logic [1:0] r; string nm; } note_t;
  note_t       notes_q[$];                          // Expected read results
  logic [1:0]  resp_q[$];                           // Expected write responses
  note_t       seen_n;                              // Oldest note
  int          miscompares, samples_checked, cycles, i, j, k;
  logic [31:0] rnd, v;                              // Random source, scratch

  initial aclk = 1'b0;
  always #10 aclk = ~aclk;                          // 50 MHz

  descriptor_attribute_regs uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .usb_reset, .lite_reset, .image_load,
    .eeprom_present, .otp_configured, .emulation_select_bit,
    .img_bos_len, .img_ss_poll, .img_ss_dev_len, .img_ss_cfg_len,
    .img_hs_poll, .img_hs_dev_len, .img_hs_cfg_len, .epc_read_done,
    .epc_read_byte, .eeprom_byte_value, .attr_active, .bos_len_eff,
    .ss_poll_eff, .ss_dev_len_eff, .ss_cfg_len_eff, .hs_poll_eff,
    .hs_dev_len_eff, .hs_cfg_len_eff);

  // ----------------------------------------------------------------
  // Helpers: random source, compare, verdict
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic nx;
    rnd = lfsr(rnd);
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (e !== g)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus master: each task starts just after a rising edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    resp_q.push_back(er);
    // Ends once s_axi_bvalid is seen; the bench timeout catches a hang
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    // Extra edge so the next task never re-raises in the same step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er, input string nm);
    notes_q.push_back(note_t'{d, er, nm});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    // Ends once s_axi_rvalid is seen; the bench timeout catches a hang
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
  endtask
  task automatic rd_img(input logic [7:0] b, sp, sd, sc, hp, hd, hc);
    rd(OFF_BOS, {24'h0, b}, RESP_OKAY, "bos");
    rd(OFF_SS, {8'h0, sp, sd, sc}, RESP_OKAY, "ss");
    rd(OFF_HS, {8'h0, hp, hd, hc}, RESP_OKAY, "hs");
  endtask
  task automatic scramble;
    nx; wr(OFF_BOS, rnd, RESP_OKAY);
    nx; wr(OFF_SS, {rnd[31:16], LEN_DFLT, DESC_LEN_STD}, RESP_OKAY);
    nx; wr(OFF_HS, {rnd[31:16], DESC_LEN_STD, LEN_DFLT}, RESP_OKAY);
  endtask

  // Read monitor: oldest note against each accepted read beat
  always @(posedge aclk)
    if (s_axi_rvalid && s_axi_rready)
    begin
      seen_n = notes_q.size() ? notes_q.pop_front() : note_t'{'1, '1, "none"};
      chk(seen_n.nm, seen_n.d, s_axi_rdata);
      chk("rresp", {30'h0, seen_n.r}, {30'h0, s_axi_rresp});
    end

  // Write monitor: oldest expected response against each accepted beat
  always @(posedge aclk)
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", {30'h0, resp_q.size() ? resp_q.pop_front() : 2'b11},
          {30'h0, s_axi_bresp});

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      miscompares++;
      final_report;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, usb_reset, lite_reset, image_load} = '0;
    {eeprom_present, otp_configured, emulation_select_bit} = '0;
    {img_bos_len, img_ss_poll, img_ss_dev_len, img_ss_cfg_len} = '0;
    {img_hs_poll, img_hs_dev_len, img_hs_cfg_len} = '0;
    {epc_read_done, epc_read_byte} = '0;
    rnd = 32'h55CDA2F4;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Fixed defaults before any image load, unmapped read refused
    rd_img(LEN_DFLT, SS_POLL_DFLT, 8'h00, 8'h00, HS_POLL_DFLT, 8'h00, 8'h00);
    rd(12'h048, 32'h0, RESP_SLVERR, "unmapped");
    chk("ss_poll_eff", {24'h0, SS_POLL_DFLT}, {24'h0, ss_poll_eff});
    $display("test reset_values done");
    // Reserved bits, unmapped write, length clamp on the SS side
    // Nonzero BOS size presumes a BOS descriptor in RAM
    wr(OFF_BOS, 32'hFFFFFFFF, RESP_OKAY);
    wr(12'h04C, 32'h00000011, RESP_SLVERR);
    rd(OFF_BOS, 32'h000000FF, RESP_OKAY, "bos");
    for (i = 0; i < 4; i++)
    begin
      nx;
      v = rnd;
      if (i == 0) v[15:0] = 16'h0000;   // Absent blocks
      // Standard size; RAM holds config then interface
      if (i == 1) v[15:0] = 16'h1212;
      wr(OFF_SS, v, RESP_OKAY);
      rd(OFF_SS, v & 32'h00FFFFFF, RESP_OKAY, "ss");
      chk("ss_dev", {24'h0, v[15:8] != 0 ? DESC_LEN_STD : LEN_DFLT}, {24'h0, ss_dev_len_eff});
      chk("ss_cfg", {24'h0, v[7:0] != 0 ? DESC_LEN_STD : LEN_DFLT}, {24'h0, ss_cfg_len_eff});
      chk("ss_poll", {24'h0, v[23:16]}, {24'h0, ss_poll_eff});
      // HS sizes are only ever zero or the standard length
      v[15:8] = (v[15:8] != 8'h00) ? DESC_LEN_STD : LEN_DFLT;
      v[7:0]  = (v[7:0] != 8'h00) ? DESC_LEN_STD : LEN_DFLT;
      wr(OFF_HS, v, RESP_OKAY);
      rd(OFF_HS, v & 32'h00FFFFFF, RESP_OKAY, "hs");
      chk("hs_poll", {24'h0, v[23:16]}, {24'h0, hs_poll_eff});
      chk("hs_dev", {24'h0, v[15:8]}, {24'h0, hs_dev_len_eff});
      chk("hs_cfg", {24'h0, v[7:0]}, {24'h0, hs_cfg_len_eff});
    end
    $display("test attribute_writes done");
    // Byte buffer from software, then from a finished EEPROM read
    nx;
    wr(OFF_BYTE_BUF, rnd, RESP_OKAY);
    rd(OFF_BYTE_BUF, {24'h0, rnd[7:0]}, RESP_OKAY, "buf");
    chk("byte_val", {24'h0, rnd[7:0]}, {24'h0, eeprom_byte_value});
    epc_read_byte <= ~rnd[7:0];
    epc_read_done <= 1'b1;
    @(posedge aclk);
    epc_read_done <= 1'b0;
    rd(OFF_BYTE_BUF, {24'h0, ~rnd[7:0]}, RESP_OKAY, "buf");
    $display("test byte_buffer done");
    // Image loads (EEPROM, then OTP), restored by USB and lite reset
    for (j = 0; j < 2; j++)
    begin
      nx;
      {img_bos_len, img_ss_poll, img_ss_dev_len, img_ss_cfg_len} <= rnd;
      nx;
      {img_hs_poll, img_hs_dev_len, img_hs_cfg_len} <= rnd[23:0];
      eeprom_present <= (j == 0);
      otp_configured <= (j == 1);
      image_load     <= 1'b1;
      @(posedge aclk);
      // Sources drop away; later writes are accepted with or without them
      {image_load, eeprom_present, otp_configured} <= 3'b000;
      @(posedge aclk);
      for (k = 0; k < 3; k++)
      begin
        if (k > 0)
        begin
          scramble;
          usb_reset  <= (k == 1);
          lite_reset <= (k == 2);
          @(posedge aclk);
          {usb_reset, lite_reset} <= 2'b00;
          @(posedge aclk);
        end
        rd_img(img_bos_len, img_ss_poll, img_ss_dev_len, img_ss_cfg_len, img_hs_poll, img_hs_dev_len, img_hs_cfg_len);
        chk("bos_eff", {24'h0, img_bos_len}, {24'h0, bos_len_eff});
      end
    end
    // Load with no image source brings back the fixed defaults
    image_load <= 1'b1;
    @(posedge aclk);
    image_load <= 1'b0;
    @(posedge aclk);
    scramble;
    usb_reset <= 1'b1;
    @(posedge aclk);
    usb_reset <= 1'b0;
    @(posedge aclk);
    rd_img(LEN_DFLT, SS_POLL_DFLT, 8'h00, 8'h00, HS_POLL_DFLT, 8'h00, 8'h00);
    $display("test image_restore done");
    // Attributes in force only in emulation mode with no image source
    for (i = 0; i < 8; i++)
    begin
      {eeprom_present, otp_configured, emulation_select_bit} <= i[2:0];
      @(posedge aclk);
      @(negedge aclk);
      chk("attr_active", {31'h0, i == 1}, {31'h0, attr_active});
      @(posedge aclk);
    end
    $display("test attr_active done");
    final_report;
  end
endmodule
`default_nettype wire
